/* File: rtl/usr_pkg.sv */
// package: register map, field positions and timing for the status block
package usr_pkg;
    // register offsets (byte addresses on the parallel bus)
    localparam logic [7:0] ADDR_INT_LOW = 8'h18;
    localparam logic [7:0] ADDR_CHIP_IDENTIFICATION = 8'h70;
    localparam logic [7:0] ADDR_FRAME = 8'h74;
    localparam logic [7:0] ADDR_SCRATCH = 8'h78;
    // interrupt-source bit positions
    localparam int BIT_ENDPOINT0_RX_FLAG = 10;
    localparam int BIT_SETUP = 8;
    localparam int BIT_VBUS = 7;
    localparam int BIT_DMA = 6;
    localparam int BIT_HS = 5;
    localparam int BIT_RESUME = 4;
    localparam int BIT_SUSPEND_CHANGE_FLAG = 3;
    localparam int BIT_PSEUDO_FRAME_TICK_FLAG = 2;
    localparam int BIT_SOF = 1;
    localparam int BIT_BUS_RESET_FLAG = 0;
    // reserved bits: interrupt bits 15..11 and 9, frame bits 15..14
    localparam logic [15:0] INT_MASK = 16'h05FF;
    localparam logic [15:0] FRAME_MASK = 16'h3FFF;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    // frame field layout
    localparam int MICRO_LSB = 11;
    localparam int FRAME_W = 11;
    // identification fields, values arbitrary
    localparam logic [7:0] ID_CODE_LOW = 8'hA1;
    localparam logic [7:0] ID_CODE_HIGH = 8'hB2;
    localparam logic [7:0] ID_VERSION = 8'hC3;
    // timing at 20 MHz
    localparam int CLK_PERIOD_NS = 50;
    localparam int FS_TICK_NS = 1000000;
    localparam int HS_TICK_NS = 125000;
    localparam int SE0_TIME_NS = 2000000;
    localparam int FS_TICK_CYC = FS_TICK_NS / CLK_PERIOD_NS;
    localparam int HS_TICK_CYC = HS_TICK_NS / CLK_PERIOD_NS;
    localparam int SE0_CYC = SE0_TIME_NS / CLK_PERIOD_NS;
endpackage

/* File: rtl/usr_status_regs.sv */
// status, identification, frame number and scratch registers
// Functional notes
// - endpoint 0 receive buffer event sets interrupt bit 10
// - setup token on endpoint 0 sets interrupt bit 8
// - rising edge of bus supply sense sets interrupt bit 7
// - change of dma reason register sets interrupt bit 6
// - full-speed to high-speed change sets interrupt bit 5
// - full-speed suspend never sets the high-speed change bit
// - suspend to resume change sets interrupt bit 4
// - active to suspend change sets interrupt bit 3
// - internal pseudo frame tick, 1 ms fs or 125 us hs, sets bit 2
// - received start-of-frame sets interrupt bit 1
// - bus reset sets bit 0 unless on-the-go mode is set
// - in on-the-go mode bit 0 flags se0 held for 2 ms
// - read-only 24-bit identification at 70h, unaffected by resets
// - frame register at 74h holds last sof, cleared by reset and by bus reset outside on-the-go mode
// - 8-bit reads of frame register return low byte then high
// - 16-bit scratch at 78h, read/write, cleared by reset and by bus reset outside on-the-go mode
module usr_status_regs #(
    parameter int FS_TICK = usr_pkg::FS_TICK_CYC,
    parameter int HS_TICK = usr_pkg::HS_TICK_CYC,
    parameter int SE0_HOLD = usr_pkg::SE0_CYC
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // parallel register bus
    input wire logic [7:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic bus_wide,
    input wire logic [15:0] bus_wdata,
    input wire logic int_clear,
    input wire logic [15:0] int_clear_bits,
    output logic [23:0] bus_rdata,
    // core events
    input wire logic ep0_rx_evt,
    input wire logic setup_evt,
    input wire logic vbus_sense,
    input wire logic dma_reason_chg,
    input wire logic high_speed,
    input wire logic suspended,
    input wire logic sof_evt,
    input wire logic [10:0] sof_frame,
    input wire logic [2:0] sof_micro,
    input wire logic usb_bus_reset,
    input wire logic se0_line,
    input wire logic otg_mode,
    // status out
    output logic [15:0] int_status
);
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [15:0] int_ff, nxt_int;
    logic [15:0] frame_ff, nxt_frame;
    logic [15:0] scratch_ff, nxt_scratch;
    logic [23:0] rdata_ff, nxt_rdata;
    logic byte_sel_ff, nxt_byte_sel;
    logic vbus_ff, hs_ff, suspend_change_flag_ff;
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic [31:0] se0_cnt_ff, nxt_se0_cnt;
    logic [15:0] set_bits;
    logic pseudo_frame_tick_flag_tick, se0_done;

    // reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
    assign rst_n = rst_sync_ff[1];

    // pseudo frame tick and se0 duration counters
    always_comb begin
        pseudo_frame_tick_flag_tick = 1'b0;
        se0_done = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 32'h1;
        if (tick_cnt_ff >= 32'(high_speed ? HS_TICK - 1 : FS_TICK - 1)) begin
            nxt_tick_cnt = 32'h0;
            pseudo_frame_tick_flag_tick = 1'b1;
        end
        nxt_se0_cnt = 32'h0;
        if (se0_line) begin
            // count only up to the hold time so one flag per se0 period
            nxt_se0_cnt = (se0_cnt_ff == 32'(SE0_HOLD)) ? se0_cnt_ff
                : se0_cnt_ff + 32'h1;
            se0_done = (se0_cnt_ff == 32'(SE0_HOLD - 1));
        end
    end

    // event decode into interrupt-source bits
    always_comb begin
        set_bits = 16'h0000;
        set_bits[usr_pkg::BIT_ENDPOINT0_RX_FLAG] = ep0_rx_evt;
        set_bits[usr_pkg::BIT_SETUP] = setup_evt;
        set_bits[usr_pkg::BIT_VBUS] = vbus_sense & ~vbus_ff;
        set_bits[usr_pkg::BIT_DMA] = dma_reason_chg;
        // suspend in full speed drops no high-speed edge, so no set
        set_bits[usr_pkg::BIT_HS] = high_speed & ~hs_ff;
        set_bits[usr_pkg::BIT_RESUME] = suspend_change_flag_ff & ~suspended;
        set_bits[usr_pkg::BIT_SUSPEND_CHANGE_FLAG] = suspended & ~suspend_change_flag_ff;
        set_bits[usr_pkg::BIT_PSEUDO_FRAME_TICK_FLAG] = pseudo_frame_tick_flag_tick;
        set_bits[usr_pkg::BIT_SOF] = sof_evt;
        set_bits[usr_pkg::BIT_BUS_RESET_FLAG] = otg_mode ? se0_done
            : usb_bus_reset;
    end

    // register next values; set wins over a software clear
    always_comb begin
        nxt_int = int_ff;
        nxt_frame = frame_ff;
        nxt_scratch = scratch_ff;
        if (int_clear) nxt_int = int_ff & ~int_clear_bits;
        nxt_int = (nxt_int | set_bits) & usr_pkg::INT_MASK;
        if (sof_evt) begin
            // reserved top bits are masked so they always read zero
            nxt_frame = {2'h0, sof_micro, sof_frame}
                & usr_pkg::FRAME_MASK;
        end
        if (bus_wr && bus_addr == usr_pkg::ADDR_SCRATCH) begin
            nxt_scratch = bus_wdata;
        end
        if (usb_bus_reset && !otg_mode) begin
            nxt_frame = usr_pkg::RESET_ZERO;
            nxt_scratch = usr_pkg::RESET_ZERO;
        end
    end

    // read decode; 8-bit frame reads alternate low then high byte
    always_comb begin
        nxt_rdata = 24'h000000;
        nxt_byte_sel = byte_sel_ff;
        if (bus_rd) begin
            if (bus_addr == usr_pkg::ADDR_CHIP_IDENTIFICATION) begin
                nxt_rdata = {usr_pkg::ID_CODE_LOW, usr_pkg::ID_CODE_HIGH,
                    usr_pkg::ID_VERSION};
            end else if (bus_addr == usr_pkg::ADDR_FRAME) begin
                if (bus_wide) begin
                    nxt_rdata = {8'h00, frame_ff};
                    nxt_byte_sel = 1'b0;
                end else begin
                    nxt_rdata = {16'h0000, byte_sel_ff ? frame_ff[15:8]
                        : frame_ff[7:0]};
                    nxt_byte_sel = ~byte_sel_ff;
                end
            end else if (bus_addr == usr_pkg::ADDR_SCRATCH) begin
                nxt_rdata = {8'h00, scratch_ff};
            end else if (bus_addr == usr_pkg::ADDR_INT_LOW) begin
                nxt_rdata = {8'h00, int_ff};
            end
        end
    end

    // state registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ff <= 16'h0000;
            frame_ff <= 16'h0000;
            scratch_ff <= 16'h0000;
            rdata_ff <= 24'h000000;
            byte_sel_ff <= 1'b0;
            vbus_ff <= 1'b0;
            hs_ff <= 1'b0;
            suspend_change_flag_ff <= 1'b0;
            tick_cnt_ff <= 32'h0;
            se0_cnt_ff <= 32'h0;
        end else if (clk_en) begin
            int_ff <= nxt_int;
            frame_ff <= nxt_frame;
            scratch_ff <= nxt_scratch;
            rdata_ff <= nxt_rdata;
            byte_sel_ff <= nxt_byte_sel;
            vbus_ff <= vbus_sense;
            hs_ff <= high_speed;
            suspend_change_flag_ff <= suspended;
            tick_cnt_ff <= nxt_tick_cnt;
            se0_cnt_ff <= nxt_se0_cnt;
        end
    end

    assign bus_rdata = rdata_ff;
    assign int_status = int_ff;

    // checks
    property p_vbus;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && vbus_sense && !vbus_ff |=> int_ff[usr_pkg::BIT_VBUS];
    endproperty
    a_vbus: assert property (p_vbus) else $error("vbus flag missed");
    property p_suspend_change_flag;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && suspended && !suspend_change_flag_ff |=> int_ff[usr_pkg::BIT_SUSPEND_CHANGE_FLAG];
    endproperty
    a_suspend_change_flag: assert property (p_suspend_change_flag) else $error("suspend missed");
    property p_resume;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && !suspended && suspend_change_flag_ff |=> int_ff[usr_pkg::BIT_RESUME];
    endproperty
    a_resume: assert property (p_resume) else $error("resume missed");
    property p_sof;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && sof_evt && !usb_bus_reset |=> int_ff[usr_pkg::BIT_SOF]
            && frame_ff[10:0] == $past(sof_frame);
    endproperty
    a_sof: assert property (p_sof) else $error("sof not captured");
    property p_rsvd;
        @(posedge ref_clk) disable iff (!rst_n)
        !int_ff[9] && frame_ff[15:14] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_otg;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && otg_mode && usb_bus_reset && !se0_done && !int_ff[0]
            |=> !int_ff[0];
    endproperty
    a_otg: assert property (p_otg) else $error("reset in otg mode");
    property p_scratch;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && bus_wr && bus_addr == usr_pkg::ADDR_SCRATCH
            && !usb_bus_reset |=> scratch_ff == $past(bus_wdata);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch");
    property p_id;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && bus_rd && bus_addr == usr_pkg::ADDR_CHIP_IDENTIFICATION |=>
            bus_rdata == {usr_pkg::ID_CODE_LOW, usr_pkg::ID_CODE_HIGH,
            usr_pkg::ID_VERSION};
    endproperty
    a_id: assert property (p_id) else $error("id value wrong");
    property p_hs;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && !high_speed && !int_ff[5] && !int_clear |=> !int_ff[5];
    endproperty
    a_hs: assert property (p_hs) else $error("hs flag spurious");
    // endpoint 0 receive event lands in its flag
    property p_endpoint0_rx_flag;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && ep0_rx_evt |=> int_ff[usr_pkg::BIT_ENDPOINT0_RX_FLAG];
    endproperty
    a_endpoint0_rx_flag: assert property (p_endpoint0_rx_flag)
        else $error("ep0 receive flag missed");
    // setup token lands in its flag
    property p_setup;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && setup_evt |=> int_ff[usr_pkg::BIT_SETUP];
    endproperty
    a_setup: assert property (p_setup)
        else $error("setup flag missed");
    // dma reason change lands in its flag
    property p_dma;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && dma_reason_chg |=> int_ff[usr_pkg::BIT_DMA];
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma flag missed");
    // entering high speed sets the speed change flag
    property p_hs_set;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && high_speed && !hs_ff |=> int_ff[usr_pkg::BIT_HS];
    endproperty
    a_hs_set: assert property (p_hs_set)
        else $error("high speed flag missed");
    // a pseudo tick sets its flag and restarts the period
    property p_pseudo_frame_tick_flag;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && pseudo_frame_tick_flag_tick |=> int_ff[usr_pkg::BIT_PSEUDO_FRAME_TICK_FLAG]
            && tick_cnt_ff == 32'h0;
    endproperty
    a_pseudo_frame_tick_flag: assert property (p_pseudo_frame_tick_flag)
        else $error("pseudo tick flag missed");
    // the tick counter never runs past the longer period
    property p_tick_bound;
        @(posedge ref_clk) disable iff (!rst_n)
        tick_cnt_ff < 32'(FS_TICK);
    endproperty
    a_tick_bound: assert property (p_tick_bound)
        else $error("pseudo tick period overrun");
    // bus reset flags and clears frame and scratch outside otg mode
    property p_brst;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && usb_bus_reset && !otg_mode |=> int_ff[usr_pkg::BIT_BUS_RESET_FLAG]
            && frame_ff == 16'h0000 && scratch_ff == 16'h0000;
    endproperty
    a_brst: assert property (p_brst)
        else $error("bus reset not applied");
    // long se0 in otg mode reports on bit 0
    property p_se0;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && otg_mode && se0_done |=> int_ff[usr_pkg::BIT_BUS_RESET_FLAG];
    endproperty
    a_se0: assert property (p_se0)
        else $error("se0 hold not flagged");
    // first narrow frame read returns the low byte
    property p_byte;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && bus_rd && !bus_wide && bus_addr == usr_pkg::ADDR_FRAME
            && !byte_sel_ff |=> bus_rdata == {16'h0000, $past(frame_ff[7:0])};
    endproperty
    a_byte: assert property (p_byte)
        else $error("frame low byte wrong");
    // a held clock enable freezes flags and scratch
    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> $stable(int_ff) && $stable(scratch_ff);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while frozen");
    c_pseudo_frame_tick_flag: cover property (@(posedge ref_clk) pseudo_frame_tick_flag_tick);
    c_otg: cover property (@(posedge ref_clk) otg_mode && se0_done);
    c_narrow: cover property (@(posedge ref_clk) bus_rd && !bus_wide);
    c_brst: cover property (@(posedge ref_clk) int_ff[0]);
    c_byte: cover property (@(posedge ref_clk) byte_sel_ff);
endmodule

/* File: verification/usr_host_model.sv */
// far-side host model: frames, bus reset and line states
module usr_host_model (
    // clock
    input wire logic ref_clk,
    // link events as the device core sees them
    output logic sof_evt,
    output logic [10:0] sof_frame,
    output logic [2:0] sof_micro,
    output logic usb_bus_reset,
    output logic se0_line,
    output logic high_speed,
    output logic suspended
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle link, full speed, awake
    initial begin
        sof_evt = 1'b0;
        sof_frame = 11'h000;
        sof_micro = 3'h0;
        usb_bus_reset = 1'b0;
        se0_line = 1'b0;
        high_speed = 1'b0;
        suspended = 1'b0;
    end
    // settle time so registered flags have landed
    task automatic settle();
        repeat (4) @(negedge ref_clk);
    endtask
    // fields are valid only with the strobe, garbage otherwise
    task automatic sof(input logic [10:0] f, input logic [2:0] m);
        @(negedge ref_clk);
        sof_evt = 1'b1;
        sof_frame = f;
        sof_micro = m;
        @(negedge ref_clk);
        sof_evt = 1'b0;
        sof_frame = ~f;
        sof_micro = ~m;
        settle();
    endtask
    task automatic bus_reset_flag();
        @(negedge ref_clk);
        usb_bus_reset = 1'b1;
        @(negedge ref_clk);
        usb_bus_reset = 1'b0;
        settle();
    endtask
    // both data lines low for n cycles
    task automatic se0(input int n);
        @(negedge ref_clk);
        se0_line = 1'b1;
        repeat (n) @(negedge ref_clk);
        se0_line = 1'b0;
        settle();
    endtask
    task automatic line(input logic hs, input logic sp);
        @(negedge ref_clk);
        high_speed = hs;
        suspended = sp;
        settle();
    endtask
endmodule

/* File: verification/usr_status_regs_bench.sv */
// self-checking bench for the status register block
module usr_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FS = 20;
    localparam logic [23:0] ID = {usr_pkg::ID_CODE_LOW,
        usr_pkg::ID_CODE_HIGH, usr_pkg::ID_VERSION};
    logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
    logic bus_rd = 1'b0, bus_wr = 1'b0, bus_wide = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [15:0] bus_wdata = 16'h0000, int_clear_bits = 16'h0000;
    logic int_clear = 1'b0, ep0_rx_evt = 1'b0, setup_evt = 1'b0;
    logic vbus_sense = 1'b0, dma_reason_chg = 1'b0, otg_mode = 1'b0;
    logic sof_evt, usb_bus_reset, se0_line, high_speed, suspended;
    logic [10:0] sof_frame;
    logic [2:0] sof_micro;
    logic [23:0] bus_rdata, d;
    logic [15:0] int_status;
    int err_count = 0, comparisons = 0, cyc = 0;
    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;
    // short tick counts keep the run brief
    usr_status_regs #(.FS_TICK(FS), .HS_TICK(5), .SE0_HOLD(10))
    i_usr_status_regs (.ref_clk, .resetn, .clk_en, .bus_addr, .bus_rd,
        .bus_wr, .bus_wide, .bus_wdata, .int_clear, .int_clear_bits,
        .bus_rdata, .ep0_rx_evt, .setup_evt, .vbus_sense,
        .dma_reason_chg, .high_speed, .suspended, .sof_evt, .sof_frame,
        .sof_micro, .usb_bus_reset, .se0_line, .otg_mode, .int_status);
    usr_host_model i_usr_host_model (.ref_clk, .sof_evt, .sof_frame,
        .sof_micro, .usb_bus_reset, .se0_line, .high_speed, .suspended);
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // read data lands the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic w);
        @(negedge ref_clk);
        bus_addr = a;
        bus_wide = w;
        bus_rd = 1'b1;
        @(negedge ref_clk);
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge ref_clk);
        bus_addr = a;
        bus_wdata = v;
        bus_wr = 1'b1;
        @(negedge ref_clk);
        bus_wr = 1'b0;
    endtask
    task automatic clr(input logic [15:0] m);
        @(negedge ref_clk);
        int_clear_bits = m;
        int_clear = 1'b1;
        @(negedge ref_clk);
        int_clear = 1'b0;
    endtask
    task automatic cmp(input string s, input logic [23:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // the free-running pseudo tick is masked out where it would race
    task automatic chk_st(input logic [15:0] e, m);
        cmp("int_status", {8'h00, e}, {8'h00, int_status & m});
    endtask
    task automatic t_regs();
        rd(usr_pkg::ADDR_CHIP_IDENTIFICATION, 1'b1);
        cmp("chip_identification", ID, d);
        rd(usr_pkg::ADDR_SCRATCH, 1'b1);
        cmp("scratch", 24'h000000, d);
        wr(usr_pkg::ADDR_SCRATCH, 16'hA55A);
        rd(usr_pkg::ADDR_SCRATCH, 1'b1);
        cmp("scratch", 24'h00A55A, d);
        wr(usr_pkg::ADDR_CHIP_IDENTIFICATION, 16'h0000);
        rd(usr_pkg::ADDR_CHIP_IDENTIFICATION, 1'b1);
        cmp("chip_identification", ID, d);
        rd(8'h40, 1'b1);
        cmp("unmapped", 24'h000000, d);
        i_usr_host_model.bus_reset_flag();
        rd(usr_pkg::ADDR_SCRATCH, 1'b1);
        cmp("scratch", 24'h000000, d);
        wr(usr_pkg::ADDR_SCRATCH, 16'h1234);
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        tick(4);
        rd(usr_pkg::ADDR_SCRATCH, 1'b1);
        cmp("scratch", 24'h000000, d);
        rd(usr_pkg::ADDR_CHIP_IDENTIFICATION, 1'b1);
        cmp("chip_identification", ID, d);
    endtask
    task automatic t_events();
        int b[4] = '{10, 8, 7, 6};
        foreach (b[i]) begin
            clr(16'hFFFF);
            ep0_rx_evt = (b[i] == 10);
            setup_evt = (b[i] == 8);
            vbus_sense = (b[i] == 7);
            dma_reason_chg = (b[i] == 6);
            tick(1);
            {ep0_rx_evt, setup_evt, dma_reason_chg} = 3'b000;
            tick(4);
            chk_st(16'h0001 << b[i], 16'hFFFB);
        end
        clr(16'hFFFF);
        i_usr_host_model.line(1'b0, 1'b1);
        chk_st(16'h0008, 16'hFFFB);
        clr(16'hFFFF);
        i_usr_host_model.line(1'b0, 1'b0);
        chk_st(16'h0010, 16'hFFFB);
        // no write lock lives here, so scratch takes writes after resume
        wr(usr_pkg::ADDR_SCRATCH, 16'h5AA5);
        rd(usr_pkg::ADDR_SCRATCH, 1'b1);
        cmp("scratch", 24'h005AA5, d);
        clr(16'hFFFF);
        i_usr_host_model.line(1'b1, 1'b0);
        chk_st(16'h0020, 16'hFFFB);
    endtask
    task automatic t_pseudo_frame_tick_flag();
        clr(16'h0004);
        tick(6);
        chk_st(16'h0004, 16'h0004);
        i_usr_host_model.line(1'b0, 1'b0);
        clr(16'h0004);
        tick(FS + 2);
        chk_st(16'h0004, 16'h0004);
    endtask
    task automatic t_otg();
        otg_mode = 1'b1;
        clr(16'hFFFF);
        i_usr_host_model.bus_reset_flag();
        i_usr_host_model.se0(4);
        chk_st(16'h0000, 16'hFFFB);
        i_usr_host_model.se0(14);
        chk_st(16'h0001, 16'hFFFB);
        otg_mode = 1'b0;
        clr(16'hFFFF);
        i_usr_host_model.bus_reset_flag();
        chk_st(16'h0001, 16'hFFFB);
    endtask
    task automatic t_frame();
        clr(16'hFFFF);
        i_usr_host_model.sof(11'h7FF, 3'h5);
        chk_st(16'h0002, 16'hFFFB);
        rd(usr_pkg::ADDR_FRAME, 1'b1);
        cmp("frame", 24'h002FFF, d);
        rd(usr_pkg::ADDR_FRAME, 1'b0);
        cmp("frame low", 24'h0000FF, d);
        rd(usr_pkg::ADDR_FRAME, 1'b0);
        cmp("frame high", 24'h00002F, d);
        wr(usr_pkg::ADDR_FRAME, 16'h0000);
        rd(usr_pkg::ADDR_FRAME, 1'b1);
        cmp("frame", 24'h002FFF, d);
        i_usr_host_model.bus_reset_flag();
        rd(usr_pkg::ADDR_FRAME, 1'b1);
        cmp("frame", 24'h000000, d);
    endtask
    // with the enable low neither events nor writes may land
    task automatic t_freeze();
        clr(16'hFFFF);
        clk_en = 1'b0;
        ep0_rx_evt = 1'b1;
        tick(1);
        ep0_rx_evt = 1'b0;
        wr(usr_pkg::ADDR_SCRATCH, 16'hBEEF);
        clk_en = 1'b1;
        tick(2);
        chk_st(16'h0000, 16'hFFFB);
        rd(usr_pkg::ADDR_SCRATCH, 1'b1);
        cmp("scratch", 24'h000000, d);
    endtask
    task automatic results();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    initial begin
        tick(16);
        resetn = 1'b1;
        tick(4);
        t_regs();
        t_events();
        t_pseudo_frame_tick_flag();
        t_otg();
        t_frame();
        t_freeze();
        results();
    end
endmodule
